/* File: hdl/usx_pkg.sv */
`default_nettype none
package usx_pkg;

    // Oversample tick positions within one bit time
    localparam logic [4:0] RT_FIRST = 5'h01;
    localparam logic [4:0] RT_VERIFY_A = 5'h03;
    localparam logic [4:0] RT_VERIFY_B = 5'h05;
    localparam logic [4:0] RT_VERIFY_C = 5'h07;
    localparam logic [4:0] RT_SAMPLE_A = 5'h08;
    localparam logic [4:0] RT_SAMPLE_B = 5'h09;
    localparam logic [4:0] RT_SAMPLE_C = 5'h0a;
    localparam logic [4:0] RT_LAST = 5'h10;

    // Transmit ticks per bit, counted 0 to 15
    localparam logic [3:0] TX_TICK_LAST = 4'hf;

    // Frame lengths in bits, start and stop included
    localparam logic [3:0] TX_FRAME_BITS_8 = 4'ha;
    localparam logic [3:0] TX_FRAME_BITS_9 = 4'hb;

    // Data bits per character
    localparam logic [3:0] RX_DATA_BITS_8 = 4'h8;
    localparam logic [3:0] RX_DATA_BITS_9 = 4'h9;

    // Bit positions inside the received character
    localparam int RX_BIT_SEVEN = 7;
    localparam int RX_BIT_EIGHT = 8;

    // Line levels
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_START = 1'b0;
    localparam logic LINE_STOP = 1'b1;

    // Reset values of the transmit status flags
    localparam logic TX_EMPTY_RESET = 1'b1;
    localparam logic TX_COMPLETE_RESET = 1'b1;

    localparam logic [2:0] HISTORY_ONES = 3'h7;

    typedef enum logic [1:0] {
        RX_SEARCH = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } usx_rx_state_t;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } usx_tx_state_t;

    typedef struct packed {
        logic tx_invert;
        logic nine_bit_chars;
        logic tx_empty_irq_enable;
        logic tx_complete_irq_enable;
        logic rx_full_irq_enable;
    } usx_ctrl_t;

    typedef struct packed {
        logic rx_full_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic overrun_flag;
        logic rx_ninth_bit;
    } usx_rx_status_t;

    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_complete_flag;
    } usx_tx_status_t;

endpackage

`default_nettype wire

/* File: hdl/usx_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none

module usx_serial_port (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Control bits and oversample tick from the baud generator
    input wire usx_pkg::usx_ctrl_t ctrl,
    input wire logic oversample_tick,
    // Transmit buffer write
    input wire logic tx_data_write,
    input wire logic [8:0] tx_data,
    // Receive buffer read
    input wire logic rx_data_read,
    // Serial pins
    input wire logic rxd,
    output logic txd,
    // Buffer and status
    output logic [7:0] serial_data_buffer,
    output usx_pkg::usx_rx_status_t rx_status,
    output usx_pkg::usx_tx_status_t tx_status,
    // Interrupt requests
    output logic tx_irq,
    output logic rx_irq
);
    import usx_pkg::*;

    // ---------------- Transmitter ----------------
    usx_tx_state_t tx_state;
    logic [8:0] tx_buffer;
    logic tx_buffer_full;
    logic [10:0] tx_frame;
    logic [3:0] tx_bits_left;
    logic [3:0] tx_tick_count;
    logic tx_load;
    logic tx_bit_done;

    // Transfer only at a tick so a new frame starts on the bit grid
    assign tx_load = (tx_state == TX_IDLE) && tx_buffer_full && oversample_tick;
    assign tx_bit_done = oversample_tick && (tx_tick_count == TX_TICK_LAST);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_buffer <= 9'h000;
            tx_buffer_full <= 1'b0;
        end else if (tx_data_write) begin
            tx_buffer <= tx_data;
            tx_buffer_full <= 1'b1;
        end else if (tx_load) begin
            tx_buffer_full <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_state <= TX_IDLE;
            tx_frame <= {11{LINE_IDLE}};
            tx_bits_left <= 4'h0;
            tx_tick_count <= 4'h0;
        end else if (tx_load) begin
            tx_state <= TX_SHIFT;
            tx_tick_count <= 4'h0;
            if (ctrl.nine_bit_chars) begin
                tx_frame <= {LINE_STOP, tx_buffer[8], tx_buffer[7:0], LINE_START};
                tx_bits_left <= TX_FRAME_BITS_9;
            end else begin
                tx_frame <= {LINE_IDLE, LINE_STOP, tx_buffer[7:0], LINE_START};
                tx_bits_left <= TX_FRAME_BITS_8;
            end
        end else if (tx_state == TX_SHIFT) begin
            if (oversample_tick) begin
                tx_tick_count <= tx_tick_count + 4'h1;
            end
            if (tx_bit_done) begin
                tx_frame <= {LINE_IDLE, tx_frame[10:1]};
                tx_bits_left <= tx_bits_left - 4'h1;
                if (tx_bits_left == 4'h1) begin
                    tx_state <= TX_IDLE;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            txd <= LINE_IDLE;
        end else if (tx_state == TX_SHIFT) begin
            txd <= tx_frame[0] ^ ctrl.tx_invert;
        end else begin
            txd <= LINE_IDLE ^ ctrl.tx_invert;
        end
    end

    // Complete follows the hardware state; a write in the transfer cycle leaves the buffer full with the empty flag set
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_status.tx_buffer_empty_flag <= TX_EMPTY_RESET;
            tx_status.tx_complete_flag <= TX_COMPLETE_RESET;
        end else begin
            if (tx_load) begin
                tx_status.tx_buffer_empty_flag <= 1'b1;
            end else if (tx_data_write) begin
                tx_status.tx_buffer_empty_flag <= 1'b0;
            end
            tx_status.tx_complete_flag <= !tx_buffer_full && !tx_data_write
                && !tx_load && (tx_state == TX_IDLE);
        end
    end

    assign tx_irq = (tx_status.tx_buffer_empty_flag && ctrl.tx_empty_irq_enable)
        || (tx_status.tx_complete_flag && ctrl.tx_complete_irq_enable);

    // ---------------- Receiver ----------------
    logic rxd_meta;
    logic rxd_sync;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rxd_meta <= LINE_IDLE;
            rxd_sync <= LINE_IDLE;
        end else begin
            // Only the second stage feeds logic; the first may still be settling
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    usx_rx_state_t rx_state;
    logic [4:0] rt_count;
    logic [2:0] history;
    logic [2:0] verify_samples;
    logic [2:0] bit_samples;
    logic [8:0] rx_shift;
    logic [3:0] rx_bit_index;
    logic char_noise;
    logic last_sample;
    logic resync_armed;
    logic [3:0] data_bits;
    logic [2:0] verify_now;
    logic [2:0] bits_now;
    logic voted;
    logic falling;
    logic char_done;
    logic char_framing;
    logic char_noise_final;
    logic verify_level;
    logic verify_mixed;
    logic bits_mixed;

    assign data_bits = ctrl.nine_bit_chars ? RX_DATA_BITS_9 : RX_DATA_BITS_8;
    assign verify_now = {verify_samples[2:1], rxd_sync};
    assign bits_now = {bit_samples[2:1], rxd_sync};
    assign falling = last_sample && !rxd_sync;
    assign char_done = oversample_tick && (rx_state == RX_STOP) && (rt_count == RT_SAMPLE_C);
    assign char_framing = !voted;
    assign char_noise_final = char_noise || bits_mixed;

    // One voter per sample group; both see the live third sample
    usx_vote3 verify_vote_i (
        .samples(verify_now),
        .level(verify_level),
        .mixed(verify_mixed)
    );

    usx_vote3 bit_vote_i (
        .samples(bits_now),
        .level(voted),
        .mixed(bits_mixed)
    );

    // Sample pipeline, one step per oversample tick
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            history <= 3'h0;
            last_sample <= LINE_IDLE;
            verify_samples <= 3'h0;
            bit_samples <= 3'h0;
        end else if (oversample_tick) begin
            history <= (rx_state == RX_SEARCH) ? {history[1:0], rxd_sync} : 3'h0;
            last_sample <= rxd_sync;
            if (rt_count == RT_VERIFY_A) begin
                verify_samples[2] <= rxd_sync;
            end
            if (rt_count == RT_VERIFY_B) begin
                verify_samples[1] <= rxd_sync;
            end
            if (rt_count == RT_SAMPLE_A) begin
                bit_samples[2] <= rxd_sync;
            end
            if (rt_count == RT_SAMPLE_B) begin
                bit_samples[1] <= rxd_sync;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rx_state <= RX_SEARCH;
            rt_count <= RT_FIRST;
            rx_shift <= 9'h000;
            rx_bit_index <= 4'h0;
            char_noise <= 1'b0;
            resync_armed <= 1'b0;
        end else if (oversample_tick) begin
            rt_count <= (rt_count == RT_LAST) ? RT_FIRST : rt_count + 5'h01;
            case (rx_state)
                RX_SEARCH: begin
                    rt_count <= RT_FIRST;
                    if (history == HISTORY_ONES && !rxd_sync) begin
                        rx_state <= RX_START;
                        rt_count <= RT_FIRST + 5'h01;
                        char_noise <= 1'b0;
                        resync_armed <= 1'b0;
                    end
                end
                RX_START: begin
                    if (rt_count == RT_VERIFY_C) begin
                        if (!verify_level) begin
                            char_noise <= verify_mixed;
                        end else begin
                            rx_state <= RX_SEARCH;
                            rt_count <= RT_FIRST;
                        end
                    end
                    if (rt_count == RT_SAMPLE_C && |bits_now) begin
                        char_noise <= 1'b1;
                    end
                    if (rt_count == RT_LAST) begin
                        rx_state <= RX_DATA;
                        rx_bit_index <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rt_count == RT_SAMPLE_C) begin
                        rx_shift[rx_bit_index] <= voted;
                        char_noise <= char_noise || bits_mixed;
                        resync_armed <= voted;
                    end
                    // Realign on a 1 to 0 data edge, whether early or late
                    // A short low glitch after a voted 1 realigns as well; no filter
                    if (resync_armed && falling && rt_count != RT_SAMPLE_C) begin
                        resync_armed <= 1'b0;
                        rt_count <= RT_FIRST + 5'h01;
                        if (rt_count > RT_SAMPLE_C) begin
                            if (rx_bit_index == data_bits - 4'h1) begin
                                rx_state <= RX_STOP;
                            end
                            rx_bit_index <= rx_bit_index + 4'h1;
                        end
                    end else if (rt_count == RT_LAST) begin
                        if (rx_bit_index == data_bits - 4'h1) begin
                            rx_state <= RX_STOP;
                        end
                        rx_bit_index <= rx_bit_index + 4'h1;
                    end
                end
                RX_STOP: begin
                    if (rt_count == RT_SAMPLE_C) begin
                        // History restarts, so RT11..13 of the stop bit refill it
                        rx_state <= RX_SEARCH;
                        rt_count <= RT_FIRST;
                    end
                end
                default: begin
                    rx_state <= RX_SEARCH;
                    rt_count <= RT_FIRST;
                end
            endcase
        end
    end

    // Receive buffer and flags; a new event wins over a clearing read
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            serial_data_buffer <= 8'h00;
            rx_status <= '0;
        end else if (char_done) begin
            if (rx_status.rx_full_flag && !rx_data_read) begin
                // The new character and its noise are dropped
                rx_status.overrun_flag <= 1'b1;
            end else begin
                serial_data_buffer <= rx_shift[7:0];
                rx_status.rx_ninth_bit <= ctrl.nine_bit_chars ? rx_shift[RX_BIT_EIGHT]
                    : rx_shift[RX_BIT_SEVEN];
                rx_status.rx_full_flag <= 1'b1;
                rx_status.framing_error_flag <= char_framing;
                rx_status.noise_flag <= char_noise_final;
                rx_status.overrun_flag <= 1'b0;
            end
        end else if (rx_data_read) begin
            rx_status.rx_full_flag <= 1'b0;
            rx_status.framing_error_flag <= 1'b0;
            rx_status.noise_flag <= 1'b0;
            rx_status.overrun_flag <= 1'b0;
        end
    end

    assign rx_irq = rx_status.rx_full_flag && ctrl.rx_full_irq_enable;

endmodule

// Three-sample vote shared by start verification and bit recovery
module usx_vote3 (
    // Samples of one group
    input wire logic [2:0] samples,
    // Majority level and disagreement
    output logic level,
    output logic mixed
);
    import usx_pkg::*;

    assign level = (samples[0] & samples[1]) | (samples[0] & samples[2])
        | (samples[1] & samples[2]);
    // Any 1 and any 0 together means the samples disagree
    assign mixed = (|samples) && !(&samples);

endmodule

`default_nettype wire

/* File: bench/usx_serial_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module usx_serial_port_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Port inputs
    input wire usx_pkg::usx_ctrl_t ctrl,
    input wire logic oversample_tick,
    input wire logic tx_data_write,
    input wire logic [8:0] tx_data,
    input wire logic rx_data_read,
    input wire logic rxd,
    // Port outputs
    input wire logic txd,
    input wire logic [7:0] serial_data_buffer,
    input wire usx_pkg::usx_rx_status_t rx_status,
    input wire usx_pkg::usx_tx_status_t tx_status,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    import usx_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_handover;
        $rose(tx_status.tx_buffer_empty_flag);
    endsequence
    sequence s_char_done;
        $rose(rx_status.rx_full_flag);
    endsequence
    rx_irq_level_a: assert property (rx_irq == (rx_status.rx_full_flag & ctrl.rx_full_irq_enable))
        else $error("rx_irq does not follow full flag and enable");
    tx_irq_level_a: assert property (tx_irq == ((tx_status.tx_buffer_empty_flag &
        ctrl.tx_empty_irq_enable) | (tx_status.tx_complete_flag & ctrl.tx_complete_irq_enable)))
        else $error("tx_irq does not follow flags and enables");
    // Invert is registered into txd, so a fresh change is given one cycle
    idle_line_a: assert property ($past(reset_n) && tx_status.tx_complete_flag &&
        $stable(ctrl.tx_invert) |-> txd == (LINE_IDLE ^ ctrl.tx_invert))
        else $error("txd not idle while transmission complete");
    start_first_a: assert property (s_handover |=> txd == (LINE_START ^ ctrl.tx_invert))
        else $error("no start bit after handover");
    handover_tick_a: assert property (s_handover |-> $past(oversample_tick))
        else $error("handover away from a tick");
    write_clears_a: assert property (tx_data_write |=> !tx_status.tx_buffer_empty_flag &&
        !tx_status.tx_complete_flag)
        else $error("write did not clear empty and complete");
    fe_with_full_a: assert property ($rose(rx_status.framing_error_flag) &&
        !$past(rx_data_read) |-> $rose(rx_status.rx_full_flag))
        else $error("framing error apart from full flag");
    full_on_tick_a: assert property (s_char_done |-> $past(oversample_tick))
        else $error("full flag away from a tick");
    ninth_copy_a: assert property ((s_char_done and !ctrl.nine_bit_chars) |->
        rx_status.rx_ninth_bit == serial_data_buffer[RX_BIT_SEVEN])
        else $error("ninth bit not a copy of bit seven");
    buffer_kept_a: assert property (rx_status.rx_full_flag && !rx_data_read |=>
        $stable(serial_data_buffer) && rx_status.rx_full_flag)
        else $error("unread buffer changed");
endmodule
bind usx_serial_port usx_serial_port_sva usx_serial_port_sva_i (.clock, .reset_n, .ctrl,
    .oversample_tick, .tx_data_write, .tx_data, .rx_data_read, .rxd, .txd,
    .serial_data_buffer, .rx_status, .tx_status, .tx_irq, .rx_irq);
`default_nettype wire

/* File: bench/usx_line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module usx_line_partner (
    // Clock, reset and tick
    input wire logic clock,
    input wire logic reset_n,
    input wire logic oversample_tick,
    // Frame request: go pulses for one cycle, the other fields are held by the caller while busy
    input wire logic go,
    input wire logic [11:0] frame,
    input wire logic [3:0] nbits,
    input wire logic [3:0] gbit,
    input wire logic [15:0] gmask,
    // Line side
    output logic rxd,
    output logic busy
);
    logic [3:0] idx;
    logic [3:0] ph;
    // Glitches only land where gmask asks, one bit per frame
    always_ff @(posedge clock) begin
        if (!reset_n || go) begin
            busy <= go && reset_n;
            idx <= 4'h0;
            ph <= 4'h0;
            if (!reset_n) rxd <= 1'b1;
        end else if (busy && oversample_tick) begin
            if (idx == nbits) begin
                rxd <= 1'b1;
                busy <= 1'b0;
            end else begin
                rxd <= frame[idx] ^ (idx == gbit && gmask[ph]);
                ph <= ph + 4'h1;
                idx <= idx + {3'h0, ph == 4'hf};
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import usx_pkg::*;
    typedef struct packed {
        logic nine;
        logic [8:0] d;
        logic stop;
        logic [3:0] gb;
        logic [15:0] gm;
        logic nz;
        logic fe;
    } usx_row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    usx_ctrl_t ctrl = '0;
    logic oversample_tick = 1'b0;
    logic tx_data_write = 1'b0;
    logic [8:0] tx_data = '0;
    logic rx_data_read = 1'b0;
    logic go = 1'b0;
    logic [11:0] frame = '1;
    logic [3:0] nbits = 4'ha;
    logic [3:0] gbit = 4'hf;
    logic [15:0] gmask = '0;
    logic [1:0] tdiv = 2'h0;
    logic rxd, txd, busy, tx_irq, rx_irq;
    logic [7:0] serial_data_buffer;
    usx_rx_status_t rx_status;
    usx_tx_status_t tx_status;
    int fails = 0;
    int n_tests = 0;
    usx_row_t rows [12];
    always #5 clock = ~clock;
    // Four clocks per tick keeps a frame near 700 cycles
    always @(posedge clock) begin
        tdiv <= tdiv + 2'h1;
        oversample_tick <= (tdiv == 2'h3);
    end
    usx_serial_port usx_serial_port_i (.clock, .reset_n, .ctrl, .oversample_tick,
        .tx_data_write, .tx_data, .rx_data_read, .rxd, .txd, .serial_data_buffer,
        .rx_status, .tx_status, .tx_irq, .rx_irq);
    usx_line_partner usx_line_partner_i (.clock, .reset_n, .oversample_tick, .go,
        .frame, .nbits, .gbit, .gmask, .rxd, .busy);
    task automatic chk_bit(input string n, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b got %b", n, e, g);
        end
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask
    task automatic final_report;
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic send(input usx_row_t r);
        @(posedge clock);
        ctrl.nine_bit_chars <= r.nine;
        ctrl.rx_full_irq_enable <= ~ctrl.rx_full_irq_enable;
        frame <= r.nine ? {1'b1, r.stop, r.d, 1'b0} : {2'b11, r.stop, r.d[7:0], 1'b0};
        nbits <= r.nine ? 4'hb : 4'ha;
        gbit <= r.gb;
        gmask <= r.gm;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        while (busy) @(posedge clock);
        repeat (24) @(posedge clock);
        #1;
    endtask
    task automatic read_buf;
        @(posedge clock);
        rx_data_read <= 1'b1;
        @(posedge clock);
        rx_data_read <= 1'b0;
    endtask
    task automatic wait_ticks(input int n);
        repeat (n) do @(posedge clock); while (oversample_tick !== 1'b1);
    endtask
    task automatic tx_frame(input logic nine, input logic inv, input logic [8:0] d);
        logic [10:0] f;
        f = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
        @(posedge clock);
        ctrl.nine_bit_chars <= nine;
        ctrl.tx_invert <= inv;
        ctrl.tx_empty_irq_enable <= nine;
        ctrl.tx_complete_irq_enable <= ~nine;
        repeat (2) @(posedge clock);
        #1;
        chk_bit("txd idle", ~inv, txd);
        @(posedge clock);
        tx_data_write <= 1'b1;
        tx_data <= d;
        @(posedge clock);
        tx_data_write <= 1'b0;
        do begin @(posedge clock); #1; end while (!tx_status.tx_buffer_empty_flag);
        wait_ticks(8);
        for (int k = 0; k < (nine ? 11 : 10); k++) begin
            #1;
            chk_bit("txd bit", f[k] ^ inv, txd);
            if (k == 0) chk_bit("tx_irq busy", nine, tx_irq);
            wait_ticks(16);
        end
        wait_ticks(24);
        #1;
        chk_bit("txd end", ~inv, txd);
        chk_bit("tx complete", 1'b1, tx_status.tx_complete_flag);
        chk_bit("tx_irq end", 1'b1, tx_irq);
    endtask
    initial begin
        rows = '{'{1'b0, 9'h0a5, 1'b1, 4'hf, 16'h0000, 1'b0, 1'b0},
            '{1'b1, 9'h15a, 1'b1, 4'hf, 16'h0000, 1'b0, 1'b0},
            '{1'b1, 9'h0a5, 1'b1, 4'hf, 16'h0000, 1'b0, 1'b0},
            '{1'b0, 9'h03c, 1'b1, 4'h0, 16'h0004, 1'b1, 1'b0},
            '{1'b0, 9'h0c3, 1'b1, 4'h0, 16'h0010, 1'b1, 1'b0},
            '{1'b0, 9'h066, 1'b1, 4'h0, 16'h0040, 1'b1, 1'b0},
            '{1'b0, 9'h081, 1'b1, 4'h0, 16'h0100, 1'b1, 1'b0},
            '{1'b0, 9'h055, 1'b1, 4'h3, 16'h0100, 1'b1, 1'b0},
            '{1'b0, 9'h000, 1'b0, 4'hf, 16'h0000, 1'b0, 1'b1},
            '{1'b0, 9'h02b, 1'b1, 4'h9, 16'h0080, 1'b1, 1'b0},
            '{1'b0, 9'h001, 1'b0, 4'h9, 16'h0100, 1'b1, 1'b1},
            '{1'b1, 9'h07f, 1'b1, 4'ha, 16'h0200, 1'b1, 1'b0}};
        repeat (5) @(posedge clock);
        #1;
        chk_bit("txd reset", LINE_IDLE, txd);
        chk_bit("empty reset", TX_EMPTY_RESET, tx_status.tx_buffer_empty_flag);
        chk_bit("complete reset", TX_COMPLETE_RESET, tx_status.tx_complete_flag);
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (8) @(posedge clock);
        foreach (rows[i]) begin
            send(rows[i]);
            chk_bit("rx full", 1'b1, rx_status.rx_full_flag);
            chk_bit("rx_irq", ctrl.rx_full_irq_enable, rx_irq);
            chk_byte("buffer", rows[i].d[7:0], serial_data_buffer);
            chk_bit("ninth", rows[i].nine ? rows[i].d[8] : rows[i].d[7],
                rx_status.rx_ninth_bit);
            chk_bit("noise", rows[i].nz, rx_status.noise_flag);
            chk_bit("framing", rows[i].fe, rx_status.framing_error_flag);
            read_buf;
        end
        // Low for two ticks only: rejected, then the next frame must still be found
        send('{1'b1, 9'h1ff, 1'b1, 4'h0, 16'hfffc, 1'b0, 1'b0});
        chk_bit("false start", 1'b0, rx_status.rx_full_flag);
        send('{1'b0, 9'h012, 1'b1, 4'hf, 16'h0000, 1'b0, 1'b0});
        send('{1'b0, 9'h034, 1'b1, 4'hf, 16'h0000, 1'b0, 1'b0});
        chk_bit("overrun", 1'b1, rx_status.overrun_flag);
        chk_byte("kept", 8'h12, serial_data_buffer);
        read_buf;
        #1;
        chk_bit("read clears", 1'b0, rx_status.rx_full_flag);
        tx_frame(1'b0, 1'b0, 9'h0a5);
        tx_frame(1'b1, 1'b1, 9'h1c3);
        tx_frame(1'b0, 1'b1, 9'h13c);
        tx_frame(1'b1, 1'b0, 9'h0f0);
        final_report;
    end
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
